/* hdl/sar_ctrl_pkg.sv */
// constants used by the converter control, which passes the word width on to its result shift register
package sar_ctrl_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 50_000_000;
	localparam int unsigned CAL_DELAY_MS    = 40;
	localparam int unsigned CAL_RUN_MS      = 400;
	localparam int unsigned CAL_RUN_HOT_MS  = 550;
	localparam int unsigned CAL_DELAY_CYC   = CAL_DELAY_MS * (CLK_HZ / 1000);
	localparam int unsigned CAL_RUN_CYC     = CAL_RUN_MS * (CLK_HZ / 1000);
	localparam int unsigned CONV_NS         = 700;
	localparam int unsigned CLK_NS          = 20;
	localparam int unsigned CONV_CYC        = (CONV_NS + CLK_NS - 1) / CLK_NS;
	// ----------------------------------------------------------------
	// word layout
	// ----------------------------------------------------------------
	localparam int unsigned WORD_BITS_WIDE  = 14;
	localparam int unsigned WORD_BITS_NARROW = 12;

	typedef enum logic [2:0]
	{
		ST_POWER_WAIT = 3'b000,
		ST_CALIBRATE  = 3'b001,
		ST_ACQUIRE    = 3'b010,
		ST_CONVERT    = 3'b011,
		ST_DONE       = 3'b100
	} ctrl_state_t;
endpackage : sar_ctrl_pkg

/* hdl/sar_result_shift.sv */
// result word holding register shifted out msb first on serial clock falls
`timescale 1ns/100ps
`default_nettype none
module sar_result_shift #(
	parameter int unsigned WIDTH = 14
)(
	input  wire logic             sys_clk,
	input  wire logic             rstn,
	input  wire logic             clk_en,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_word,
	input  wire logic             shift,
	output logic                  msb_q
);
	logic [WIDTH-1:0] word_q;

	// load wins over shift so a fresh result is never half shifted
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			word_q <= '0;
		else if (clk_en && load)
			word_q <= load_word;
		else if (clk_en && shift)
			word_q <= {word_q[WIDTH-2:0], 1'b0};
	end

	assign msb_q = word_q[WIDTH-1];
endmodule : sar_result_shift
`default_nettype wire

/* hdl/sar_convert_ctrl.sv */
// conversion, readout and power-up calibration control of the converter
`timescale 1ns/100ps
`default_nettype none
module sar_convert_ctrl #(
	parameter int unsigned WORD_BITS     = sar_ctrl_pkg::WORD_BITS_WIDE,
	parameter int unsigned CAL_DELAY_CYC = sar_ctrl_pkg::CAL_DELAY_CYC,
	parameter int unsigned CAL_RUN_CYC   = sar_ctrl_pkg::CAL_RUN_CYC,
	parameter int unsigned CONV_CYC      = sar_ctrl_pkg::CONV_CYC
)(
	input  wire logic                 sys_clk,
	input  wire logic                 rstn,
	input  wire logic                 clk_en,
	input  wire logic                 conversion_start_select,
	input  wire logic                 sclk,
	input  wire logic                 sdi,
	input  wire logic [WORD_BITS-1:0] sample_code,
	output logic                      sdo_o,
	output logic                      sdo_oe,
	output logic                      sampling_phase,
	output logic                      cal_busy,
	output logic                      conv_busy
);
	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic cs_meta_q, cs_sync_q, cs_prev_q;
	logic ck_meta_q, ck_sync_q, ck_prev_q;
	logic sdi_meta_q, sdi_sync_q;

	// two flops per pin, third flop only for edge finding
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cs_meta_q  <= 1'b1;
			cs_sync_q  <= 1'b1;
			cs_prev_q  <= 1'b1;
			ck_meta_q  <= 1'b0;
			ck_sync_q  <= 1'b0;
			ck_prev_q  <= 1'b0;
			sdi_meta_q <= 1'b1;
			sdi_sync_q <= 1'b1;
		end
		else if (clk_en)
		begin
			cs_meta_q  <= conversion_start_select;
			cs_sync_q  <= cs_meta_q;
			cs_prev_q  <= cs_sync_q;
			ck_meta_q  <= sclk;
			ck_sync_q  <= ck_meta_q;
			ck_prev_q  <= ck_sync_q;
			sdi_meta_q <= sdi;
			sdi_sync_q <= sdi_meta_q;
		end
	end

	// ----------------------------------------------------------------
	// edge decode
	// ----------------------------------------------------------------
	wire cs_rise = cs_sync_q & ~cs_prev_q;
	wire cs_low  = ~cs_sync_q;
	wire ck_fall = ck_prev_q & ~ck_sync_q;
	// sdi is watched; a low level forces the driven sdo bit to zero
	wire sdi_ok  = sdi_sync_q;

	// ----------------------------------------------------------------
	// state and counters
	// ----------------------------------------------------------------
	localparam int unsigned CNT_W = $clog2(CAL_DELAY_CYC + CAL_RUN_CYC + CONV_CYC + 2);
	localparam int unsigned BIT_W = $clog2(WORD_BITS + 1);

	sar_ctrl_pkg::ctrl_state_t state_q, state_d;
	logic [CNT_W-1:0]          cnt_q, cnt_d;
	logic [BIT_W-1:0]          bits_q, bits_d;
	logic [WORD_BITS-1:0]      code_q;

	wire cnt_hit_delay = (cnt_q == CNT_W'(CAL_DELAY_CYC - 1));
	wire cnt_hit_cal   = (cnt_q == CNT_W'(CAL_RUN_CYC - 1));
	wire cnt_hit_conv  = (cnt_q == CNT_W'(CONV_CYC - 1));
	wire in_acquire    = (state_q == sar_ctrl_pkg::ST_ACQUIRE);
	wire in_done       = (state_q == sar_ctrl_pkg::ST_DONE);
	wire bits_left     = (bits_q != '0);
	// readout happens in acquisition after a select fall, word not yet exhausted
	wire read_window   = in_acquire & cs_low & bits_left;
	wire shift_now     = read_window & ck_fall;
	wire load_now      = in_done & cs_low;

	// next-state decode
	always_comb
	begin
		state_d = state_q;
		cnt_d   = cnt_q + CNT_W'(1);
		bits_d  = bits_q;
		case (state_q)
			sar_ctrl_pkg::ST_POWER_WAIT:
				if (cnt_hit_delay)
				begin
					state_d = sar_ctrl_pkg::ST_CALIBRATE;
					cnt_d   = '0;
				end
			sar_ctrl_pkg::ST_CALIBRATE:
				if (cnt_hit_cal)
				begin
					state_d = sar_ctrl_pkg::ST_ACQUIRE;
					cnt_d   = '0;
				end
			sar_ctrl_pkg::ST_ACQUIRE:
			begin
				cnt_d = '0;
				if (shift_now)
					bits_d = bits_q - BIT_W'(1);
				if (cs_rise)
				begin
					state_d = sar_ctrl_pkg::ST_CONVERT;
					bits_d  = '0;
				end
			end
			sar_ctrl_pkg::ST_CONVERT:
				if (cnt_hit_conv)
				begin
					state_d = sar_ctrl_pkg::ST_DONE;
					cnt_d   = '0;
				end
			sar_ctrl_pkg::ST_DONE:
			begin
				cnt_d = '0;
				if (cs_low)
				begin
					state_d = sar_ctrl_pkg::ST_ACQUIRE;
					bits_d  = BIT_W'(WORD_BITS);
				end
			end
			default:
			begin
				state_d = sar_ctrl_pkg::ST_POWER_WAIT;
				cnt_d   = '0;
			end
		endcase
	end

	// state registers; power-up calibration starts from reset release
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_q <= sar_ctrl_pkg::ST_POWER_WAIT;
			cnt_q   <= '0;
			bits_q  <= '0;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			bits_q  <= bits_d;
		end
	end

	// sample the analog code at the end of the conversion interval
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			code_q <= '0;
		else if (clk_en && state_q == sar_ctrl_pkg::ST_CONVERT && cnt_hit_conv)
			code_q <= sample_code;
	end

	// ----------------------------------------------------------------
	// result shift register
	// ----------------------------------------------------------------
	logic shift_msb;

	sar_result_shift #(
		.WIDTH     (WORD_BITS)
	) u_shift (
		.sys_clk   (sys_clk),
		.rstn      (rstn),
		.clk_en    (clk_en),
		.load      (load_now),
		.load_word (code_q),
		.shift     (shift_now),
		.msb_q     (shift_msb)
	);

	// ----------------------------------------------------------------
	// output flops
	// ----------------------------------------------------------------
	// a word is offered only after a finished conversion; a host that idles
	// select low through calibration would otherwise see sdo driven at its end
	logic word_ok_q;
	wire  word_ok_d = load_now | (word_ok_q & ~cs_rise);

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			word_ok_q <= 1'b0;
		else if (clk_en)
			word_ok_q <= word_ok_d;
	end

	// the enable follows select once a result waits
	wire sdo_drive = in_acquire & cs_low & word_ok_q & ~load_now;

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sdo_o          <= 1'b0;
			sdo_oe         <= 1'b0;
			sampling_phase <= 1'b0;
			cal_busy       <= 1'b1;
			conv_busy      <= 1'b0;
		end
		else if (clk_en)
		begin
			sdo_o          <= sdo_drive & shift_msb & sdi_ok;
			sdo_oe         <= sdo_drive;
			sampling_phase <= (state_d == sar_ctrl_pkg::ST_ACQUIRE);
			cal_busy       <= (state_d == sar_ctrl_pkg::ST_POWER_WAIT) ||
			                  (state_d == sar_ctrl_pkg::ST_CALIBRATE);
			conv_busy      <= (state_d == sar_ctrl_pkg::ST_CONVERT);
		end
	end

endmodule : sar_convert_ctrl
`default_nettype wire

/* verif/sar_ctrl_checker.sv */
// port assertions for the converter control
`timescale 1ns/100ps
`default_nettype none
module sar_ctrl_checker #(
	parameter int unsigned WORD_BITS     = 14,
	parameter int unsigned CAL_DELAY_CYC = 20,
	parameter int unsigned CAL_RUN_CYC   = 50,
	parameter int unsigned CONV_CYC      = 35
)(
	input wire logic                 sys_clk,
	input wire logic                 rstn,
	input wire logic                 clk_en,
	input wire logic                 conversion_start_select,
	input wire logic                 sclk,
	input wire logic                 sdi,
	input wire logic [WORD_BITS-1:0] sample_code,
	input wire logic                 sdo_o,
	input wire logic                 sdo_oe,
	input wire logic                 sampling_phase,
	input wire logic                 cal_busy,
	input wire logic                 conv_busy
);
	logic [31:0] up_q;
	logic [31:0] conv_q;
	// cycles since reset, length of the running conversion
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			up_q   <= 32'h0;
			conv_q <= 32'h0;
		end
		else
		begin
			// a low clock enable freezes the design, so these freeze too
			up_q   <= up_q + {31'h0, clk_en};
			conv_q <= conv_busy ? conv_q + {31'h0, clk_en} : 32'h0;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	// a small window, though cal_busy falls with up_q at exactly CAL_DELAY_CYC + CAL_RUN_CYC
	a_cal_span: assert property (
		$fell(cal_busy) |-> up_q + 32'h2 >= CAL_DELAY_CYC + CAL_RUN_CYC && up_q <= CAL_DELAY_CYC + CAL_RUN_CYC + 3)
		else $error("calibration span wrong");
	a_cal_acq: assert property (
		$fell(cal_busy) |-> ##[0:2] sampling_phase) else $error("no acquisition after calibration");
	a_cal_quiet: assert property (
		cal_busy |-> !sdo_oe) else $error("sdo driven in calibration");
	a_cal_end_quiet: assert property (
		$fell(cal_busy) |-> !sdo_oe ##1 !sdo_oe ##1 !sdo_oe) else $error("sdo driven at calibration end");
	a_desel_float: assert property (
		conversion_start_select [*5] |-> !sdo_oe) else $error("sdo driven while deselected");
	a_conv_start: assert property (
		$rose(conversion_start_select) && sampling_phase |-> ##[1:5] conv_busy) else $error("no conversion");
	a_conv_span: assert property (
		$fell(conv_busy) |-> conv_q == CONV_CYC) else $error("conversion length wrong");
	a_conv_quiet: assert property (
		conv_busy |-> !sdo_oe) else $error("sdo driven in conversion");
	a_acq_return: assert property (
		$rose(sampling_phase) |-> $past(cal_busy) || !$past(conversion_start_select)) else $error("early acquire");
	c_conv: cover property ($rose(conv_busy));
	c_read: cover property ($rose(sdo_oe));
	c_cal: cover property ($fell(cal_busy));
endmodule : sar_ctrl_checker
`default_nettype wire

/* verif/sar_host_model.sv */
// serial host: starts conversions and clocks results out
`timescale 1ns/100ps
`default_nettype none
module sar_host_model (
	input  wire logic  sys_clk,
	input  wire logic  sdo_o,
	input  wire logic  sdo_oe,
	output logic       conversion_start_select,
	output logic       sclk,
	output logic       sdi,
	output logic [13:0] rx_word,
	output logic       rx_stb
);
	logic line;
	logic last_q;
	// a floating line never repeats the last bit, so stale reads show
	assign line = sdo_oe ? sdo_o : ~last_q;
	always @(posedge sys_clk)
		last_q <= line;
	// sclk idles low outside frames
	initial
	begin
		conversion_start_select = 1'b0;
		sclk = 1'b0;
		sdi = 1'b1;
		rx_stb = 1'b0;
		rx_word = 14'h0;
		last_q = 1'b0;
	end
	task automatic conv_read();
		int i;
		@(posedge sys_clk);
		conversion_start_select <= 1'b1;
		repeat (40) @(posedge sys_clk);
		conversion_start_select <= 1'b0;
		repeat (8) @(posedge sys_clk);
		for (i = 13; i >= 0; i--)
		begin
			@(negedge sys_clk);
			rx_word[i] = line;
			@(posedge sys_clk);
			sclk <= 1'b1;
			repeat (3) @(posedge sys_clk);
			sclk <= 1'b0;
			repeat (5) @(posedge sys_clk);
		end
		rx_stb <= 1'b1;
		@(posedge sys_clk);
		rx_stb <= 1'b0;
	endtask : conv_read
endmodule : sar_host_model
`default_nettype wire

/* verif/testbench.sv */
// self-checking bench for the converter control
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic        sys_clk;
	logic        rstn;
	logic        run_en;
	logic [13:0] sample_code;
	logic        sel;
	logic        sclk;
	logic        sdi;
	logic        sdo_o;
	logic        sdo_oe;
	logic        samp;
	logic        cal;
	logic        conv;
	logic [13:0] rx_word;
	logic        rx_stb;
	logic [13:0] exp_q[$];
	int          fails = 0;
	int          n_checks = 0;
	sar_convert_ctrl #(.WORD_BITS(14), .CAL_DELAY_CYC(20), .CAL_RUN_CYC(50), .CONV_CYC(35)) u_sar_convert_ctrl (
		.sys_clk(sys_clk), .rstn(rstn), .clk_en(run_en), .conversion_start_select(sel), .sclk(sclk),
		.sdi(sdi), .sample_code(sample_code), .sdo_o(sdo_o), .sdo_oe(sdo_oe), .sampling_phase(samp),
		.cal_busy(cal), .conv_busy(conv));
	sar_host_model u_sar_host_model (.sys_clk(sys_clk), .sdo_o(sdo_o), .sdo_oe(sdo_oe),
		.conversion_start_select(sel), .sclk(sclk), .sdi(sdi), .rx_word(rx_word), .rx_stb(rx_stb));
	task automatic cmp(input string what, input logic [13:0] e, input logic [13:0] g);
		n_checks++;
		if (g !== e)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask : cmp
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : wrap_up
	// clock and watchdog
	initial
	begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial
	begin
		#200000;
		fails++;
		wrap_up();
	end
	// each word read is set against the oldest expected code
	always @(posedge sys_clk)
		if (rx_stb === 1'b1)
			cmp("sdo word", exp_q.pop_front(), rx_word);
	// two power-ups, the second with a frozen stretch; edge codes, random codes, one read per power-up with sdi low
	initial
	begin
		int i;
		int k;
		int p;
		logic [13:0] code;
		rstn = 1'b0;
		run_en = 1'b1;
		sample_code = 14'h0;
		void'($urandom(32'h9d57));
		for (p = 0; p < 2; p++)
		begin
			rstn <= 1'b0;
			repeat (20) @(posedge sys_clk);
			cmp("cal_busy", 14'h1, {13'h0, cal});
			cmp("sdo_oe", 14'h0, {13'h0, sdo_oe});
			rstn <= 1'b1;
			// freeze long enough that an ignored enable would end calibration
			if (p == 1)
			begin
				repeat (10) @(posedge sys_clk);
				run_en <= 1'b0;
				repeat (70) @(posedge sys_clk);
				cmp("cal_busy frozen", 14'h1, {13'h0, cal});
				cmp("sampling_phase frozen", 14'h0, {13'h0, samp});
				run_en <= 1'b1;
			end
			for (i = 0; i < 200 && samp !== 1'b1; i++)
				@(posedge sys_clk);
			cmp("sampling_phase", 14'h1, {13'h0, samp});
			cmp("sdo_oe idle", 14'h0, {13'h0, sdo_oe});
			for (k = 0; k < 5; k++)
			begin
				code = (k == 0) ? 14'h3fff : (k == 1) ? 14'h0 : 14'($urandom);
				@(posedge sys_clk);
				sample_code <= code;
				u_sar_host_model.sdi <= (k != 4);
				exp_q.push_back((k == 4) ? 14'h0 : code);
				u_sar_host_model.conv_read();
			end
			u_sar_host_model.sdi <= 1'b1;
		end
		// let the last strobe reach the compare process first
		repeat (2) @(posedge sys_clk);
		cmp("pending words", 14'h0, 14'(exp_q.size()));
		wrap_up();
	end
endmodule : testbench
bind sar_convert_ctrl sar_ctrl_checker #(.WORD_BITS(WORD_BITS), .CAL_DELAY_CYC(CAL_DELAY_CYC),
	.CAL_RUN_CYC(CAL_RUN_CYC), .CONV_CYC(CONV_CYC)) u_chk (.sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
	.conversion_start_select(conversion_start_select), .sclk(sclk), .sdi(sdi), .sample_code(sample_code),
	.sdo_o(sdo_o), .sdo_oe(sdo_oe), .sampling_phase(sampling_phase), .cal_busy(cal_busy), .conv_busy(conv_busy));
`default_nettype wire
